// *** rtl/rls_defs.vh ***
// What this block does
// - Subroutine return loads the program counter from the subroutine return register.
// - Taking an interrupt blocks further interrupts; interrupt return reloads its register.
// - Pushing the interrupt return register re-enables interrupt detection for nesting.
// - Unsaved interrupt return register: higher interrupts are recognized but deferred.
// - Popping the interrupt return register masks interrupts until interrupt return.
// - Exception return loads the program counter from the exception return register.
// - NMI return loads the program counter from the NMI return register.
// - Emulation return loads its register and leaves emulation mode.
// - Interrupt, exception and NMI returns need supervisor or emulation mode, else protection fault.
// - Emulation return needs emulation mode; subroutine return works in any mode.
// - Return and loop-setup instructions are never accepted paired with another.
// - Two nestable loops, each with top, bottom and count, set by setup or moves.
// - Fetch at bottom with a count above one decrements and redirects to the top.
// - A zero count neither decrements nor branches; the loop is disabled.
// - A count of one only decrements, with no branch back.
// - With equal bottoms, loop one is inner and loop zero is outer.
// - Begin offset is 5-bit unsigned even, 4 to 30, added to setup address.
// - End offset is 11-bit unsigned even, 4 to 2046, added to setup address.
// - Loop entry costs nothing when the top follows setup; penalty only on entry.
// - Setup may load the count from a pointer register, direct or shifted by one.
// - Counts are 32-bit unsigned; loop-setup instructions are 32-bit.
`ifndef RLS_DEFS_VH
`define RLS_DEFS_VH
`define RLS_ADR_CTRL      8'h00
`define RLS_ADR_STATUS    8'h04
`define RLS_ADR_SUB_RET   8'h08
`define RLS_ADR_INT_RET   8'h0C
`define RLS_ADR_EXC_RET   8'h10
`define RLS_ADR_NMI_RET   8'h14
`define RLS_ADR_EMU_RET   8'h18
`define RLS_ADR_LTOP0     8'h20
`define RLS_ADR_LBOT0     8'h24
`define RLS_ADR_LCNT0     8'h28
`define RLS_ADR_LTOP1     8'h30
`define RLS_ADR_LBOT1     8'h34
`define RLS_ADR_LCNT1     8'h38
`define RLS_CTRL_SUPER    0
`define RLS_CTRL_EMU      1
`define RLS_ST_INT_BLOCK  0
`define RLS_ST_INT_MASK   1
`define RLS_ST_PENDING    2
`define RLS_OP_NONE       3'h0
`define RLS_OP_RTS        3'h1
`define RLS_OP_RTI        3'h2
`define RLS_OP_RTX        3'h3
`define RLS_OP_RTN        3'h4
`define RLS_OP_RTE        3'h5
`define RLS_OP_LSETUP     3'h6
`define RLS_BEGIN_W       5
`define RLS_END_W         11
`define RLS_SETUP_LEN     32'h0000_0004
`define RLS_ZERO32        32'h0000_0000
`define RLS_ONE32         32'h0000_0001
`endif

// *** rtl/rls_return_and_hw_loop_sequencer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "rls_defs.vh"
module rls_return_and_hw_loop_sequencer (
	input  wire        mclk,
	input  wire        rstn,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        dec_valid,
	input  wire [2:0]  dec_op,
	input  wire        dec_paired,
	input  wire [31:0] dec_pc,
	input  wire        dec_loop_sel,
	input  wire [4:0]  begin_offset_field,
	input  wire [10:0] end_offset_field,
	input  wire        dec_cnt_load,
	input  wire        dec_cnt_shift,
	input  wire        dec_src_is_sp_fp,
	input  wire [31:0] dec_ptr_val,
	input  wire        dec_call,
	input  wire [31:0] dec_next_pc,
	input  wire        irq_take,
	input  wire [31:0] irq_ret_pc,
	input  wire        irq_higher,
	input  wire        int_ret_push,
	input  wire        int_ret_pop,
	input  wire [31:0] int_ret_pop_val,
	input  wire        fetch_valid,
	input  wire [31:0] fetch_addr,
	output reg         redirect,
	output reg  [31:0] redirect_pc,
	output reg         dec_accept,
	output reg         prot_fault,
	output reg         undef_fault,
	output wire        irq_enable,
	output wire        irq_pending,
	output wire        emu_mode
);
	reg [31:0] subroutine_return_reg;
	reg [31:0] interrupt_return_reg;
	reg [31:0] exception_return_reg;
	reg [31:0] nmi_return_reg;
	reg [31:0] emulation_return_reg;
	reg [31:0] loop_top_reg    [0:1];
	reg [31:0] loop_bottom_reg [0:1];
	reg [31:0] loop_count_reg  [0:1];
	reg        super_q;
	reg        emu_q;
	reg        blk_q;
	reg        mask_q;
	reg        pend_q;
	wire       wb_req;
	wire       wb_wr;
	wire [31:0] wmask;
	wire       is_ret;
	wire       ok;
	wire       do_op;
	wire [31:0] setup_top;
	wire [31:0] setup_bot;
	wire [31:0] setup_cnt;
	wire       hit0;
	wire       hit1;
	wire       loop_hit;
	wire       loop_sel;
	wire [31:0] outer_loop_count;
	wire [31:0] inner_loop_count;
	wire [31:0] outer_loop_bottom;
	wire [31:0] inner_loop_bottom;

	// Byte enables widen to a bit mask; unselected lanes keep their old value.
	function [31:0] lane_mask;
		input [3:0] sel;
		begin
			lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [31:0] m;
		begin
			merge = (old & ~m) | (nw & m);
		end
	endfunction

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr  = wb_req & wb_we_i;
	assign wmask  = lane_mask(wb_sel_i);

	assign outer_loop_count  = loop_count_reg[0];
	assign inner_loop_count  = loop_count_reg[1];
	assign outer_loop_bottom = loop_bottom_reg[0];
	assign inner_loop_bottom = loop_bottom_reg[1];

	assign is_ret = (dec_op == `RLS_OP_RTS) | (dec_op == `RLS_OP_RTI) | (dec_op == `RLS_OP_RTX) |
		(dec_op == `RLS_OP_RTN) | (dec_op == `RLS_OP_RTE);
	// A paired return or setup is refused outright so neither ever issues dual.
	always @* begin
		dec_accept = dec_valid & ~(dec_paired & (is_ret | (dec_op == `RLS_OP_LSETUP)));
	end
	assign ok    = dec_accept & ~prot_fault & ~undef_fault;
	assign do_op = ok;

	// Offsets are unsigned and even; bit 0 is forced low so the result stays aligned.
	assign setup_top = dec_pc + {27'h0, begin_offset_field[4:1], 1'b0};
	assign setup_bot = dec_pc + {21'h0, end_offset_field[10:1], 1'b0};
	assign setup_cnt = dec_cnt_shift ? {1'b0, dec_ptr_val[31:1]} : dec_ptr_val;

	// Both bottoms are compared every fetch; loop one wins on a shared bottom.
	assign hit0     = fetch_valid & (fetch_addr == outer_loop_bottom) &
		(outer_loop_count != `RLS_ZERO32);
	assign hit1     = fetch_valid & (fetch_addr == inner_loop_bottom) &
		(inner_loop_count != `RLS_ZERO32);
	assign loop_hit = hit0 | hit1;
	assign loop_sel = hit1;

	always @* begin
		prot_fault  = 1'b0;
		undef_fault = 1'b0;
		if (dec_accept) begin
			case (dec_op)
				`RLS_OP_RTI, `RLS_OP_RTX, `RLS_OP_RTN: begin
					prot_fault = ~super_q & ~emu_q;
				end
				`RLS_OP_RTE: begin
					undef_fault = ~emu_q;
				end
				`RLS_OP_LSETUP: begin
					undef_fault = dec_cnt_load & dec_src_is_sp_fp;
				end
				default: begin
					prot_fault = 1'b0;
				end
			endcase
		end
	end

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			redirect    <= 1'b0;
			redirect_pc <= `RLS_ZERO32;
		end else begin
			redirect    <= 1'b0;
			redirect_pc <= redirect_pc;
			if (do_op) begin
				case (dec_op)
					`RLS_OP_RTS: begin
						redirect    <= 1'b1;
						redirect_pc <= subroutine_return_reg;
					end
					`RLS_OP_RTI: begin
						redirect    <= 1'b1;
						redirect_pc <= interrupt_return_reg;
					end
					`RLS_OP_RTX: begin
						redirect    <= 1'b1;
						redirect_pc <= exception_return_reg;
					end
					`RLS_OP_RTN: begin
						redirect    <= 1'b1;
						redirect_pc <= nmi_return_reg;
					end
					`RLS_OP_RTE: begin
						redirect    <= 1'b1;
						redirect_pc <= emulation_return_reg;
					end
					`RLS_OP_LSETUP: begin
						// Sequential top needs no redirect, so entry costs nothing.
						if (setup_top != dec_pc + `RLS_SETUP_LEN) begin
							redirect    <= 1'b1;
							redirect_pc <= setup_top;
						end
					end
					default: begin
						redirect <= 1'b0;
					end
				endcase
			end else if (loop_hit) begin
				// Count one decrements without branching back.
				if (loop_count_reg[loop_sel] != `RLS_ONE32) begin
					redirect    <= 1'b1;
					redirect_pc <= loop_top_reg[loop_sel];
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_loop
			always @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					loop_top_reg[g]    <= `RLS_ZERO32;
					loop_bottom_reg[g] <= `RLS_ZERO32;
					loop_count_reg[g]  <= `RLS_ZERO32;
				end else begin
					// Setup loads top and bottom, and the count only with dec_cnt_load; a move reaches one register.
					if (do_op && dec_op == `RLS_OP_LSETUP && dec_loop_sel == g) begin
						loop_top_reg[g]    <= setup_top;
						loop_bottom_reg[g] <= setup_bot;
						if (dec_cnt_load) begin
							loop_count_reg[g] <= setup_cnt;
						end
					end else begin
						if (wb_wr && wb_adr_i == (g ? `RLS_ADR_LTOP1 : `RLS_ADR_LTOP0)) begin
							loop_top_reg[g] <= merge(loop_top_reg[g], wb_dat_i, wmask);
						end
						if (wb_wr && wb_adr_i == (g ? `RLS_ADR_LBOT1 : `RLS_ADR_LBOT0)) begin
							loop_bottom_reg[g] <= merge(loop_bottom_reg[g], wb_dat_i, wmask);
						end
						if (wb_wr && wb_adr_i == (g ? `RLS_ADR_LCNT1 : `RLS_ADR_LCNT0)) begin
							loop_count_reg[g] <= merge(loop_count_reg[g], wb_dat_i, wmask);
						end else if (!do_op && loop_hit && loop_sel == g) begin
							loop_count_reg[g] <= loop_count_reg[g] - `RLS_ONE32;
						end
					end
				end
			end
		end
	endgenerate

	// Interrupt nesting state; a take in the same cycle as a push or return wins.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			blk_q  <= 1'b0;
			mask_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			if (irq_take) begin
				blk_q <= 1'b1;
			end else if (int_ret_push) begin
				blk_q <= 1'b0;
			end else if (do_op && dec_op == `RLS_OP_RTI) begin
				blk_q <= 1'b0;
			end
			if (int_ret_pop) begin
				mask_q <= 1'b1;
			end else if (do_op && dec_op == `RLS_OP_RTI) begin
				mask_q <= 1'b0;
			end
			if (irq_higher && (blk_q || mask_q)) begin
				pend_q <= 1'b1;
			end else if (irq_take || !(blk_q || mask_q)) begin
				pend_q <= 1'b0;
			end
		end
	end
	assign irq_enable  = ~blk_q & ~mask_q;
	assign irq_pending = pend_q;
	assign emu_mode    = emu_q;

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			subroutine_return_reg <= `RLS_ZERO32;
			interrupt_return_reg  <= `RLS_ZERO32;
			exception_return_reg  <= `RLS_ZERO32;
			nmi_return_reg        <= `RLS_ZERO32;
			emulation_return_reg  <= `RLS_ZERO32;
			super_q               <= 1'b1;
			emu_q                 <= 1'b0;
		end else begin
			if (dec_call) begin
				subroutine_return_reg <= dec_next_pc;
			end else if (wb_wr && wb_adr_i == `RLS_ADR_SUB_RET) begin
				subroutine_return_reg <= merge(subroutine_return_reg, wb_dat_i, wmask);
			end
			if (irq_take) begin
				interrupt_return_reg <= irq_ret_pc;
			end else if (int_ret_pop) begin
				interrupt_return_reg <= int_ret_pop_val;
			end else if (wb_wr && wb_adr_i == `RLS_ADR_INT_RET) begin
				interrupt_return_reg <= merge(interrupt_return_reg, wb_dat_i, wmask);
			end
			if (wb_wr && wb_adr_i == `RLS_ADR_EXC_RET) begin
				exception_return_reg <= merge(exception_return_reg, wb_dat_i, wmask);
			end
			if (wb_wr && wb_adr_i == `RLS_ADR_NMI_RET) begin
				nmi_return_reg <= merge(nmi_return_reg, wb_dat_i, wmask);
			end
			if (wb_wr && wb_adr_i == `RLS_ADR_EMU_RET) begin
				emulation_return_reg <= merge(emulation_return_reg, wb_dat_i, wmask);
			end
			if (do_op && dec_op == `RLS_OP_RTE) begin
				emu_q <= 1'b0;
			end else if (wb_wr && wb_adr_i == `RLS_ADR_CTRL && wb_sel_i[0]) begin
				emu_q <= wb_dat_i[`RLS_CTRL_EMU];
			end
			if (wb_wr && wb_adr_i == `RLS_ADR_CTRL && wb_sel_i[0]) begin
				super_q <= wb_dat_i[`RLS_CTRL_SUPER];
			end
		end
	end

	// Single-wait slave: ack one cycle after the strobe, unmapped reads return zero.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `RLS_ZERO32;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= `RLS_ZERO32;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`RLS_ADR_CTRL:    wb_dat_o <= {30'h0, emu_q, super_q};
					`RLS_ADR_STATUS:  wb_dat_o <= {29'h0, pend_q, mask_q, blk_q};
					`RLS_ADR_SUB_RET: wb_dat_o <= subroutine_return_reg;
					`RLS_ADR_INT_RET: wb_dat_o <= interrupt_return_reg;
					`RLS_ADR_EXC_RET: wb_dat_o <= exception_return_reg;
					`RLS_ADR_NMI_RET: wb_dat_o <= nmi_return_reg;
					`RLS_ADR_EMU_RET: wb_dat_o <= emulation_return_reg;
					`RLS_ADR_LTOP0:   wb_dat_o <= loop_top_reg[0];
					`RLS_ADR_LBOT0:   wb_dat_o <= outer_loop_bottom;
					`RLS_ADR_LCNT0:   wb_dat_o <= outer_loop_count;
					`RLS_ADR_LTOP1:   wb_dat_o <= loop_top_reg[1];
					`RLS_ADR_LBOT1:   wb_dat_o <= inner_loop_bottom;
					`RLS_ADR_LCNT1:   wb_dat_o <= inner_loop_count;
					default:          wb_dat_o <= `RLS_ZERO32;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** testbench/rls_fetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rls_fetch_model (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        run,
	input  wire logic        hold,
	input  wire logic        redirect,
	input  wire logic [31:0] redirect_pc,
	output var  logic        fetch_valid,
	output var  logic [31:0] fetch_addr
);
	// A stall keeps the address, so a bottom seen while invalid is presented again.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn || !run) begin
			fetch_valid <= 1'b0;
			fetch_addr <= 32'h0;
		end else if (redirect) begin
			fetch_valid <= 1'b1;
			fetch_addr <= redirect_pc;
		end else begin
			fetch_addr <= fetch_addr + (fetch_valid ? 32'h4 : 32'h0);
			fetch_valid <= !hold;
		end
	end
endmodule
`default_nettype wire

// *** testbench/rls_seq_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rls_defs.vh"
module rls_seq_sva (
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       dec_valid,
	input wire logic [2:0] dec_op,
	input wire logic       dec_paired,
	input wire logic       dec_src_is_sp_fp,
	input wire logic       irq_take,
	input wire logic       int_ret_pop,
	input wire logic       redirect,
	input wire logic       dec_accept,
	input wire logic       prot_fault,
	input wire logic       undef_fault,
	input wire logic       irq_enable,
	input wire logic       irq_pending,
	input wire logic       emu_mode
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Acknowledge late.");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge too long.");
	pair_refuse_a: assert property (dec_valid && dec_paired && dec_op != 0 |-> !dec_accept)
		else $error("Paired op taken.");
	prot_cause_a: assert property (prot_fault |-> dec_valid && dec_op inside {2, 3, 4})
		else $error("Stray protection fault.");
	undef_cause_a: assert property (undef_fault |-> dec_valid &&
		(dec_op == 5 && !emu_mode || dec_op == 6 && dec_src_is_sp_fp)) else $error("Stray fault.");
	rts_jump_a: assert property (dec_valid && dec_op == 1 && dec_accept |=> redirect)
		else $error("No jump on return.");
	rte_exit_a: assert property (dec_valid && dec_op == 5 && dec_accept && !undef_fault
		|=> !emu_mode) else $error("Emulation kept.");
	take_block_a: assert property (irq_take |=> !irq_enable)
		else $error("Open after take.");
	pop_mask_a: assert property (int_ret_pop |=> !irq_enable)
		else $error("Open after pop.");
	cover property (redirect && !dec_valid);
	cover property (prot_fault);
	cover property (irq_pending);
endmodule
bind rls_return_and_hw_loop_sequencer rls_seq_sva chk (.*);
`default_nettype wire

// *** testbench/test_return_and_hw_loop_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rls_defs.vh"
module test_return_and_hw_loop_sequencer;
	logic        mclk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, dec_valid = 0;
	logic        dec_paired = 0, dec_loop_sel = 0, dec_cnt_load = 0, dec_cnt_shift = 0;
	logic        dec_src_is_sp_fp = 0, irq_take = 0, irq_higher = 0, int_ret_push = 0, run = 0;
	logic        int_ret_pop = 0, hold = 0, dec_call = 0, wb_ack_o, fetch_valid, redirect;
	logic        dec_accept, prot_fault, undef_fault, irq_enable, irq_pending, emu_mode, ok, pr;
	logic [2:0]  dec_op = 0, flags, op;
	logic [1:0]  ctl;
	logic [3:0]  wb_sel_i = 0;
	logic [4:0]  begin_offset_field = 0, b;
	logic [7:0]  wb_adr_i = 0;
	logic [10:0] end_offset_field = 0, e;
	logic [31:0] wb_dat_i = 0, dec_pc = 0, dec_ptr_val = 0, dec_next_pc = 0, irq_ret_pc = 0;
	logic [31:0] int_ret_pop_val = 0, wb_dat_o, fetch_addr, redirect_pc, rd, p, c;
	logic [31:0] seed = 32'hF0CBA994, v [1:5];
	int          fails = 0, compares = 0, nred;

	rls_return_and_hw_loop_sequencer dut (.*);
	rls_fetch_model fetch (.*);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Every bus cycle starts on a fresh edge, so callers need not align themselves.
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge mclk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n == 50) begin
			fails++;
			give_verdict();
		end
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
		wb(1'b0, a, '0, 4'hF);
		check(nm, rd, x);
	endtask

	// One issue slot plus interrupt pulses; flags keep the same-cycle decode answer.
	task automatic pulse(input logic [2:0] m, input logic [2:0] o, input logic pa);
		@(posedge mclk);
		{irq_take, int_ret_push, int_ret_pop} <= m;
		{dec_valid, dec_op, dec_paired} <= {o != 3'h0, o, pa};
		#1;
		flags = {dec_accept, prot_fault, undef_fault};
		@(posedge mclk);
		{irq_take, int_ret_push, int_ret_pop, dec_valid} <= 4'h0;
		#1;
	endtask

	// Loop one owns a shared bottom while its count lasts; once it falls through,
	// fetch never comes back to that bottom, so loop zero keeps its count.
	function automatic logic [31:0] exp_trips(input logic [31:0] c0, input logic [31:0] c1);
		if (c1 != 32'h0) return c1 - 32'h1;
		return (c0 != 32'h0) ? c0 - 32'h1 : 32'h0;
	endfunction

	task automatic loops(input logic [31:0] c0, input logic [31:0] c1);
		wb(1'b1, `RLS_ADR_LTOP0, 32'h0, 4'hF);
		wb(1'b1, `RLS_ADR_LBOT0, 32'h8, 4'hF);
		wb(1'b1, `RLS_ADR_LTOP1, 32'h0, 4'hF);
		wb(1'b1, `RLS_ADR_LBOT1, 32'h8, 4'hF);
		wb(1'b1, `RLS_ADR_LCNT0, c0, 4'hF);
		wb(1'b1, `RLS_ADR_LCNT1, c1, 4'hF);
		nred = 0;
		run <= 1'b1;
		repeat (300) begin
			@(posedge mclk);
			hold <= rnd() % 4 == 0;
			nred += redirect;
		end
		run <= 1'b0;
		check("trips", nred, exp_trips(c0, c1));
		rdc("outer", `RLS_ADR_LCNT0, (c1 != 32'h0) ? c0 : 32'h0);
		rdc("inner", `RLS_ADR_LCNT1, 32'h0);
		$display("test loops %0d %0d done", c0, c1);
	endtask

	task automatic give_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		forever #2.5 mclk = ~mclk;
	end

	initial begin
		#50000;
		fails++;
		give_verdict();
	end

	initial begin
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		rdc("ctrl", `RLS_ADR_CTRL, 32'h1);
		rdc("status", `RLS_ADR_STATUS, 32'h0);
		wb(1'b1, 8'h40, '1, 4'hF);
		rdc("unmapped", 8'h40, 32'h0);
		wb(1'b1, `RLS_ADR_LTOP0, '1, 4'h1);
		rdc("lane", `RLS_ADR_LTOP0, 32'hFF);
		for (int i = 1; i < 6; i++) begin
			v[i] = rnd() & 32'hFFFF_FFFE;
			wb(1'b1, 8'(4 + 4 * i), v[i], 4'hF);
		end
		for (int k = 0; k < 40; k++) begin
			op = 3'(k % 5 + 1);
			pr = 1'(k / 5 % 2);
			ctl = 2'(k / 10);
			wb(1'b1, `RLS_ADR_CTRL, {30'h0, ctl}, 4'hF);
			pulse(3'h0, op, pr);
			ok = !pr && (op == 1 || (op < 5 && ctl != 0) || (op == 5 && ctl[1]));
			check("accept", flags[2], !pr);
			if (!pr) check("prot", flags[1], op > 1 && op < 5 && ctl == 0);
			if (!pr) check("undef", flags[0], op == 5 && !ctl[1]);
			check("redirect", redirect, ok);
			if (ok) check("target", redirect_pc, v[op]);
			if (ok && op == 5) check("emu", emu_mode, 1'b0);
		end
		$display("test returns done");
		for (int s = 0; s < 4; s++) begin
			b = s == 0 ? 5'h04 : (s == 3 ? 5'h1E : 5'(4 + 2 * (rnd() % 14)));
			e = s == 3 ? 11'h7FE : 11'(4 + 2 * (rnd() % 1022));
			p = rnd() & 32'h0FFF_FFFE;
			c = rnd();
			{begin_offset_field, end_offset_field, dec_pc, dec_ptr_val} <= {b, e, p, c};
			{dec_loop_sel, dec_cnt_load, dec_cnt_shift} <= {s[0], 1'b1, s[1]};
			pulse(3'h0, `RLS_OP_LSETUP, 1'b0);
			check("entry", redirect, b != 5'h04);
			if (b != 5'h04) check("jump", redirect_pc, p + b);
			rdc("top", 8'(32 + 16 * s[0]), p + b);
			rdc("bottom", 8'(36 + 16 * s[0]), p + e);
			rdc("count", 8'(40 + 16 * s[0]), s[1] ? c >> 1 : c);
		end
		pulse(3'h0, `RLS_OP_LSETUP, 1'b1);
		check("pairset", flags[2], 1'b0);
		dec_src_is_sp_fp <= 1'b1;
		pulse(3'h0, `RLS_OP_LSETUP, 1'b0);
		check("spfp", flags[0], 1'b1);
		check("nojump", redirect, 1'b0);
		dec_src_is_sp_fp <= 1'b0;
		rdc("kept", `RLS_ADR_LCNT1, c >> 1);
		dec_next_pc <= rnd() & 32'hFFFF_FFFE;
		dec_call <= 1'b1;
		@(posedge mclk);
		dec_call <= 1'b0;
		rdc("call", `RLS_ADR_SUB_RET, dec_next_pc);
		$display("test setup done");
		wb(1'b1, `RLS_ADR_CTRL, 32'h1, 4'hF);
		irq_ret_pc <= rnd();
		irq_higher <= 1'b1;
		pulse(3'h4, 3'h0, 1'b0);
		check("blocked", irq_enable, 1'b0);
		pulse(3'h0, 3'h0, 1'b0);
		check("pending", irq_pending, 1'b1);
		irq_higher <= 1'b0;
		rdc("saved", `RLS_ADR_INT_RET, irq_ret_pc);
		pulse(3'h2, 3'h0, 1'b0);
		check("nest", irq_enable, 1'b1);
		int_ret_pop_val <= rnd() & 32'hFFFF_FFFE;
		pulse(3'h1, 3'h0, 1'b0);
		check("masked", irq_enable, 1'b0);
		pulse(3'h0, `RLS_OP_RTI, 1'b0);
		check("rti pc", redirect_pc, int_ret_pop_val);
		check("open", irq_enable, 1'b1);
		$display("test interrupts done");
		loops(32'h1, 32'h0);
		loops(32'h3, 32'h0);
		loops(32'h0, 32'h2);
		loops(32'h2, 32'h3);
		loops(rnd() % 6, rnd() % 6);
		give_verdict();
	end
endmodule
`default_nettype wire
